// ---- src/rotary_params.svh ----
`ifndef ROTARY_PARAMS_SVH
`define ROTARY_PARAMS_SVH

// =====================================================================
// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_DECIM       8'h04
`define OFS_UNITS       8'h08
`define OFS_PULSES      8'h0C
`define OFS_SHIFT       8'h10
`define OFS_SKIP        8'h14
`define OFS_SCALE       8'h18
`define OFS_STATUS      8'h1C
`define OFS_PULSE_CNT   8'h20
`define OFS_REF_INDEX   8'h24
`define OFS_MISS_CNT    8'h28
`define OFS_QUERY_IDX   8'h2C
`define OFS_QUERY_POS   8'h30

// =====================================================================
// control field positions
`define CTRL_RECORD_BIT 0
`define CTRL_REF_EN_BIT 1
`define CTRL_QUAL_BIT   2

// =====================================================================
// reset values
`define RST_DECIM       16'h0001
`define RST_UNITS       16'h0168
`define RST_PULSES      16'h05DC
`define RST_SHIFT       32'h0000_0000
`define RST_SKIP        16'h0000

// =====================================================================
// arithmetic and timing counts
`define FRAC_BITS       16
`define DIV_STEPS       6'h20
`define DISPLAY_SPAN    32'h02D0_0000

`endif

// ---- src/rotary_pkg.sv ----
package rotary_pkg;

	// one stored acquisition sample with its position
	typedef struct packed {
		logic [31:0] index;
		logic        locked;
		logic [15:0] cycle;
		logic [31:0] degrees;
	} sample_s;

	// software steering bits
	typedef struct packed {
		logic record;
		logic ref_en;
		logic qual_en;
	} ctrl_s;

	// serial divider states
	typedef enum logic [0:0] {
		DIV_IDLE = 1'b0,
		DIV_RUN  = 1'b1
	} div_state_e;

endpackage

// ---- src/pin_edge_sync.sv ----
`timescale 1ns/100ps

module pin_edge_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);

	// =================================================================
	// two-flop synchronisers with rising edge detect
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_pin
			logic meta_reg;
			logic sync_reg;
			logic last_reg;

			// first flop is read only by the second
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					last_reg <= 1'b0;
				end else begin
					meta_reg <= pin_in[g];
					sync_reg <= meta_reg;
					last_reg <= sync_reg;
				end
			end

			assign level[g] = sync_reg;
			assign rise[g]  = sync_reg & ~last_reg;
		end
	endgenerate

endmodule // pin_edge_sync

// ---- src/rotary_sampler.sv ----
`timescale 1ns/100ps
`include "rotary_params.svh"
// Notes on behaviour
// - Store a sample every Nth external pulse; default N is one.
// - Angle per pulse equals units per cycle over pulses per cycle, read only.
// - Programmable offset is the position given to the reference pulse.
// - With capture enabled, trigger input is the top dead center pulse.
// - Skip early reference pulses; lock on the pulse whose ordinal equals count.
// - Samples stored before lock carry zero degrees; the query register counts positions backward and forward from reference.
// - With qualifier on, alarm status ANDed with trigger forms reference pulse.
// - Inactive alarm suppresses detection; active alarm re-arms it.
// - Qualifier picks one of two pulses per 720 degree cycle as zero.
// - Run at full internal rate; store next sample after detected edge.
// - Never store faster than external pulses arrive.
// - Accept pulses up to maximum rate; decimation lowers stored rate.
// - Pulses arriving faster than storage are missed, not buffered.
// - Position split into 720 degree cycle count and remaining degrees.

module rotary_sampler (
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               ext_clock_pin,
	input  wire logic               top_dead_center_pulse,
	input  wire logic               reference_qualify_signal,
	input  wire logic               acq_ready,
	output logic                    sample_store,
	output rotary_pkg::sample_s     sample_data
);

	// =================================================================
	// declarations
	rotary_pkg::ctrl_s      ctrl_reg;
	rotary_pkg::div_state_e div_state_reg;
	logic [15:0] decim_reg, units_reg, pulses_reg, skip_reg;
	logic [31:0] shift_reg, scale_reg, query_idx_reg, hrdata_reg;
	logic [31:0] pulse_cnt_reg, ref_index_reg, miss_cnt_reg, ref_seen_reg;
	logic [15:0] decim_cnt_reg, cycle_reg;
	logic [31:0] deg_reg, dvd_reg, quo_reg;
	logic [16:0] rem_reg;
	logic [5:0]  div_cnt_reg;
	logic        wr_pend_reg, start_reg, locked_reg, div_start_reg;
	logic        store_reg;
	logic [7:0]  wr_addr_reg;
	logic [2:0]  pin_level, pin_rise;
	logic        ext_rise, trig_rise, alarm_level, ref_pulse, store_due;
	logic        take, wr_fire, lock_now;
	logic [15:0] eff_decim, eff_skip;
	logic [16:0] rem_shift;
	logic [32:0] deg_sum;
	rotary_pkg::sample_s sample_reg;

	// =================================================================
	// pin synchronisers
	pin_edge_sync #(.WIDTH(3)) u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pin_in  ({reference_qualify_signal, top_dead_center_pulse, ext_clock_pin}),
		.level   (pin_level),
		.rise    (pin_rise)
	);

	// edge events and reference qualification
	assign ext_rise    = pin_rise[0];
	assign trig_rise   = pin_rise[1];
	assign alarm_level = pin_level[2];
	assign ref_pulse   = trig_rise & ctrl_reg.ref_en & ctrl_reg.record
		& (~ctrl_reg.qual_en | alarm_level);

	// zero-valued settings behave as one
	assign eff_decim = (decim_reg == 16'h0000) ? 16'h0001 : decim_reg;
	assign eff_skip  = (skip_reg == 16'h0000) ? 16'h0001 : skip_reg;

	// =================================================================
	// AHB-Lite slave: zero wait, always OKAY
	assign take      = hsel & htrans[1] & hready;
	assign wr_fire   = wr_pend_reg & hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// capture write address phase
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_pend_reg <= take & hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	// read data registered at the address phase
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			case (haddr[7:0])
				`OFS_CTRL:      hrdata_reg <= {29'h0, ctrl_reg.qual_en, ctrl_reg.ref_en,
					ctrl_reg.record};
				`OFS_DECIM:     hrdata_reg <= {16'h0000, decim_reg};
				`OFS_UNITS:     hrdata_reg <= {16'h0000, units_reg};
				`OFS_PULSES:    hrdata_reg <= {16'h0000, pulses_reg};
				`OFS_SHIFT:     hrdata_reg <= shift_reg;
				`OFS_SKIP:      hrdata_reg <= {16'h0000, skip_reg};
				`OFS_SCALE:     hrdata_reg <= scale_reg;
				`OFS_STATUS:    hrdata_reg <= {29'h0, div_state_reg == rotary_pkg::DIV_RUN,
					ctrl_reg.record, locked_reg};
				`OFS_PULSE_CNT: hrdata_reg <= pulse_cnt_reg;
				`OFS_REF_INDEX: hrdata_reg <= ref_index_reg;
				`OFS_MISS_CNT:  hrdata_reg <= miss_cnt_reg;
				`OFS_QUERY_IDX: hrdata_reg <= query_idx_reg;
				`OFS_QUERY_POS: hrdata_reg <= locked_reg ?
					(query_idx_reg - ref_index_reg) * scale_reg + shift_reg : 32'h0000_0000;
				default:        hrdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// software register writes
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_reg      <= '0;
			decim_reg     <= `RST_DECIM;
			units_reg     <= `RST_UNITS;
			pulses_reg    <= `RST_PULSES;
			shift_reg     <= `RST_SHIFT;
			skip_reg      <= `RST_SKIP;
			query_idx_reg <= 32'h0000_0000;
		end else if (wr_fire) begin
			case (wr_addr_reg)
				`OFS_CTRL: begin
					ctrl_reg.record  <= hwdata[`CTRL_RECORD_BIT];
					ctrl_reg.ref_en  <= hwdata[`CTRL_REF_EN_BIT];
					ctrl_reg.qual_en <= hwdata[`CTRL_QUAL_BIT];
				end
				`OFS_DECIM:     decim_reg     <= hwdata[15:0];
				`OFS_UNITS:     units_reg     <= hwdata[15:0];
				`OFS_PULSES:    pulses_reg    <= hwdata[15:0];
				`OFS_SHIFT:     shift_reg     <= hwdata;
				`OFS_SKIP:      skip_reg      <= hwdata[15:0];
				`OFS_QUERY_IDX: query_idx_reg <= hwdata;
				default: ;
			endcase
		end
	end

	// recording start pulse and divider restart request
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			start_reg     <= 1'b0;
			div_start_reg <= 1'b1;
		end else begin
			start_reg <= wr_fire && wr_addr_reg == `OFS_CTRL
				&& hwdata[`CTRL_RECORD_BIT] && !ctrl_reg.record;
			div_start_reg <= wr_fire
				&& (wr_addr_reg == `OFS_UNITS || wr_addr_reg == `OFS_PULSES);
		end
	end

	// =================================================================
	// serial divider for the scale result, 16 fraction bits
	assign rem_shift = {rem_reg[15:0], dvd_reg[31]};

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			div_state_reg <= rotary_pkg::DIV_IDLE;
			dvd_reg       <= 32'h0000_0000;
			rem_reg       <= 17'h0_0000;
			quo_reg       <= 32'h0000_0000;
			div_cnt_reg   <= 6'h00;
			scale_reg     <= 32'h0000_0000;
		end else begin
			case (div_state_reg)
				rotary_pkg::DIV_IDLE: begin
					if (div_start_reg) begin
						div_state_reg <= rotary_pkg::DIV_RUN;
						dvd_reg       <= {units_reg, 16'h0000};
						rem_reg       <= 17'h0_0000;
						div_cnt_reg   <= `DIV_STEPS;
					end
				end
				rotary_pkg::DIV_RUN: begin
					dvd_reg     <= {dvd_reg[30:0], 1'b0};
					div_cnt_reg <= div_cnt_reg - 6'h01;
					if (rem_shift >= {1'b0, pulses_reg}) begin
						rem_reg <= rem_shift - {1'b0, pulses_reg};
						quo_reg <= {quo_reg[30:0], 1'b1};
					end else begin
						rem_reg <= rem_shift;
						quo_reg <= {quo_reg[30:0], 1'b0};
					end
					if (div_cnt_reg == 6'h01) begin
						div_state_reg <= rotary_pkg::DIV_IDLE;
						scale_reg     <= (rem_shift >= {1'b0, pulses_reg}) ?
							{quo_reg[30:0], 1'b1} : {quo_reg[30:0], 1'b0};
					end
				end
				default: div_state_reg <= rotary_pkg::DIV_IDLE;
			endcase
		end
	end

	// =================================================================
	// pulse counting and decimation
	assign store_due = ext_rise && ctrl_reg.record
		&& decim_cnt_reg == eff_decim - 16'h0001;

	always_ff @(posedge clk_sys) begin
		if (!rst_b || start_reg) begin
			pulse_cnt_reg <= 32'h0000_0000;
			decim_cnt_reg <= 16'h0000;
		end else if (ext_rise && ctrl_reg.record) begin
			pulse_cnt_reg <= pulse_cnt_reg + 32'h0000_0001;
			decim_cnt_reg <= store_due ? 16'h0000 : decim_cnt_reg + 16'h0001;
		end
	end

	// one store per due edge, dropped when storage is busy
	always_ff @(posedge clk_sys) begin
		if (!rst_b || start_reg) begin
			store_reg    <= 1'b0;
			miss_cnt_reg <= 32'h0000_0000;
		end else begin
			store_reg <= store_due & acq_ready;
			if (store_due && !acq_ready) begin
				miss_cnt_reg <= miss_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// =================================================================
	// reference skip and lock
	assign lock_now = ref_pulse && !locked_reg
		&& ref_seen_reg + 32'h0000_0001 >= {16'h0000, eff_skip};

	always_ff @(posedge clk_sys) begin
		if (!rst_b || start_reg) begin
			ref_seen_reg  <= 32'h0000_0000;
			locked_reg    <= 1'b0;
			ref_index_reg <= 32'h0000_0000;
		end else if (ref_pulse && !locked_reg) begin
			ref_seen_reg <= ref_seen_reg + 32'h0000_0001;
			if (lock_now) begin
				locked_reg    <= 1'b1;
				ref_index_reg <= pulse_cnt_reg;
			end
		end
	end

	// position accumulator split into 720 degree cycles
	assign deg_sum = {1'b0, deg_reg} + {1'b0, scale_reg};

	always_ff @(posedge clk_sys) begin
		if (!rst_b || start_reg) begin
			deg_reg   <= 32'h0000_0000;
			cycle_reg <= 16'h0000;
		end else if (lock_now) begin
			deg_reg   <= shift_reg;
			cycle_reg <= 16'h0000;
		end else if (locked_reg && ext_rise && ctrl_reg.record) begin
			if (deg_sum >= {1'b0, `DISPLAY_SPAN}) begin
				deg_reg   <= 32'(deg_sum - {1'b0, `DISPLAY_SPAN});
				cycle_reg <= cycle_reg + 16'h0001;
			end else begin
				deg_reg <= deg_sum[31:0];
			end
		end
	end

	// =================================================================
	// sample output stream
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sample_reg <= '0;
		end else if (store_due && acq_ready) begin
			sample_reg.index   <= pulse_cnt_reg + 32'h0000_0001;
			sample_reg.locked  <= locked_reg;
			sample_reg.cycle   <= cycle_reg + 16'(locked_reg && deg_sum >= {1'b0, `DISPLAY_SPAN});
			sample_reg.degrees <= !locked_reg ? deg_reg : (deg_sum >= {1'b0, `DISPLAY_SPAN})
				? 32'(deg_sum - {1'b0, `DISPLAY_SPAN}) : deg_sum[31:0];
		end
	end

	assign sample_store = store_reg;
	assign sample_data  = sample_reg;

	// =================================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_ref_hit;
		ref_pulse && !locked_reg && ref_seen_reg + 32'h0000_0001 == {16'h0000, eff_skip};
	endsequence
	sequence s_lock_taken;
		locked_reg && ref_index_reg == $past(pulse_cnt_reg);
	endsequence
	a_store_after_edge: assert property (sample_store |-> $past(ext_rise))
		else $error("sample stored without a preceding edge");
	a_store_spacing: assert property (sample_store |=> !sample_store)
		else $error("two stores in adjacent cycles");
	a_decim_hit: assert property (ext_rise && ctrl_reg.record && acq_ready && !start_reg
		&& decim_cnt_reg == eff_decim - 16'h0001 |=> sample_store)
		else $error("decimated store missing");
	a_miss_counted: assert property (store_due && !acq_ready && !start_reg
		|=> miss_cnt_reg == $past(miss_cnt_reg) + 32'h0000_0001)
		else $error("missed sample not counted");
	a_ref_lock: assert property (s_ref_hit ##0 !start_reg |=> s_lock_taken)
		else $error("lock not taken on selected reference");
	a_qual_gate: assert property (ctrl_reg.qual_en && !alarm_level
		|=> ref_seen_reg <= $past(ref_seen_reg))
		else $error("reference passed while qualifier inactive");
	a_start_clear: assert property (start_reg
		|=> pulse_cnt_reg == 32'h0 && decim_cnt_reg == 16'h0 && !locked_reg)
		else $error("recording start did not clear counters");
	a_lock_offset: assert property (lock_now && !start_reg |=> deg_reg == $past(shift_reg))
		else $error("reference position is not the offset");
	a_degree_range: assert property (locked_reg && $past(deg_reg) < `DISPLAY_SPAN
		&& $past(locked_reg) |-> deg_reg < `DISPLAY_SPAN)
		else $error("degrees left the display cycle");
	a_div_busy: assert property (div_start_reg && div_state_reg == rotary_pkg::DIV_IDLE
		|=> (div_state_reg == rotary_pkg::DIV_RUN)[*8])
		else $error("divider stopped early");

endmodule // rotary_sampler

// ---- verif/encoder_model.sv ----
`timescale 1ns/100ps

// =====================================================================
// engine shaft encoder and reference sensor
module encoder_model (
	output logic ext_clock_pin,
	output logic top_dead_center_pulse,
	output logic reference_qualify_signal
);

	// all lines idle low, clock stands still outside frames
	initial begin
		ext_clock_pin = 1'b0;
		top_dead_center_pulse = 1'b0;
		reference_qualify_signal = 1'b0;
	end

	// one frame of n pulses, 200 ns period, reference after every ref_every pulses
	// qualifier active around pulse qual_at, plus a blip at pulse 2 with no reference
	task automatic burst(input int n, input int ref_every, input int qual_at);
		#7.3;
		for (int k = 1; k <= n; k++) begin
			reference_qualify_signal = (qual_at != 0)
				&& ((k == 2) || (k >= qual_at - 1 && k <= qual_at + 1));
			#50 ext_clock_pin = 1'b1;
			#50 top_dead_center_pulse = (ref_every != 0) && (k % ref_every == 0);
			#50 ext_clock_pin = 1'b0;
			#50 top_dead_center_pulse = 1'b0;
		end
		reference_qualify_signal = 1'b0;
	endtask

endmodule // encoder_model

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`include "rotary_params.svh"

module testbench;

	// =====================================================================
	// signals
	logic                 clk_sys;
	logic                 rst_b;
	logic                 hsel;
	logic [31:0]          haddr;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic [2:0]           hsize;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic                 hreadyout;
	logic                 hresp;
	logic                 ext_clock_pin;
	logic                 top_dead_center_pulse;
	logic                 reference_qualify_signal;
	logic                 acq_ready;
	logic                 sample_store;
	rotary_pkg::sample_s  sample_data;
	logic [31:0]          exp_q[$];
	logic [31:0]          lock_at;
	logic [31:0]          rd;
	logic [31:0]          u;
	logic [31:0]          shift;
	integer               seed;
	int                   fails;
	int                   n_tests;

	// =====================================================================
	// design, partner and clock
	rotary_sampler rotary_sampler_i (
		.clk_sys                  (clk_sys),
		.rst_b                    (rst_b),
		.hsel                     (hsel),
		.haddr                    (haddr),
		.htrans                   (htrans),
		.hwrite                   (hwrite),
		.hsize                    (hsize),
		.hwdata                   (hwdata),
		.hready                   (hreadyout),
		.hrdata                   (hrdata),
		.hreadyout                (hreadyout),
		.hresp                    (hresp),
		.ext_clock_pin            (ext_clock_pin),
		.top_dead_center_pulse    (top_dead_center_pulse),
		.reference_qualify_signal (reference_qualify_signal),
		.acq_ready                (acq_ready),
		.sample_store             (sample_store),
		.sample_data              (sample_data)
	);

	encoder_model encoder_model_i (
		.ext_clock_pin            (ext_clock_pin),
		.top_dead_center_pulse    (top_dead_center_pulse),
		.reference_qualify_signal (reference_qualify_signal)
	);

	// 40 MHz clock
	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;

	// =====================================================================
	// comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %08h expected %08h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		check(32'(exp_q.size()), 32'h0);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// =====================================================================
	// bus master: hold each phase until hready seen high
	task automatic edge_rdy();
		int w;
		w = 0;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1 && w < 100) begin
			@(posedge clk_sys);
			w++;
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		edge_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		edge_rdy();
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	// poll until the scale divider is idle
	task automatic div_wait();
		for (int i = 0; i < 40; i++) begin
			bus(1'b0, `OFS_STATUS, 32'h0);
			if (rd[2] === 1'b0)
				break;
		end
	endtask

	// new recording from the external time base
	task automatic rec(input logic q, input logic r);
		wr(`OFS_CTRL, 32'h0);
		wr(`OFS_CTRL, {29'h0, q, r, 1'b1});
	endtask

	// note expected stores, then run one encoder frame
	task automatic frame(input int n, input int te, input int qa, input int d);
		for (int k = 1; k <= n; k++)
			if (k % d == 0 && acq_ready)
				exp_q.push_back(32'(k));
		encoder_model_i.burst(n, te, qa);
		repeat (12) @(posedge clk_sys);
	endtask

	// =====================================================================
	// watcher: each stored sample against the oldest note
	always @(posedge clk_sys) begin
		if (sample_store === 1'b1) begin
			if (exp_q.size() == 0)
				check(32'h1, 32'h0);
			else
				check(sample_data.index, exp_q.pop_front());
			if (sample_data.index > lock_at) begin
				check(32'(sample_data.locked), 32'h1);
				check(sample_data.degrees, shift + (sample_data.index - lock_at) * 32'h3D70);
				check(32'(sample_data.cycle), 32'h0);
			end else if (sample_data.index < lock_at)
				check(32'(sample_data.locked), 32'h0);
		end
	end

	// watchdog
	initial begin
		#1_000_000;
		fails++;
		conclude();
	end

	// =====================================================================
	// main sequence
	initial begin
		seed = 87;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		acq_ready = 1'b1;
		lock_at = 32'hFFFF_FFFF;
		fails = 0;
		n_tests = 0;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		// reset values and unmapped place
		rdchk(`OFS_DECIM, 32'(`RST_DECIM));
		rdchk(`OFS_UNITS, 32'(`RST_UNITS));
		rdchk(`OFS_PULSES, 32'(`RST_PULSES));
		rdchk(`OFS_SHIFT, `RST_SHIFT);
		rdchk(`OFS_SKIP, 32'(`RST_SKIP));
		rdchk(8'h40, 32'h0);
		div_wait();
		rdchk(`OFS_SCALE, 32'h0000_3D70);
		wr(`OFS_SCALE, 32'h1234_5678);
		rdchk(`OFS_SCALE, 32'h0000_3D70);
		u = ($random(seed) & 32'h3FF) + 32'h1;
		wr(`OFS_UNITS, u);
		div_wait();
		rdchk(`OFS_SCALE, (u << 16) / 32'd1500);
		wr(`OFS_UNITS, 32'd360);
		div_wait();
		// decimation 1, 3 and 4 over fresh recordings
		for (int i = 0; i < 3; i++) begin
			u = (i == 0) ? 32'd1 : 32'd2 + 32'(i);
			wr(`OFS_DECIM, u);
			rec(1'b0, 1'b0);
			frame(12, 4, 0, int'(u));
			rdchk(`OFS_PULSE_CNT, 32'd12);
		end
		// acquisition path not ready: pulses missed, not buffered
		wr(`OFS_DECIM, 32'd1);
		acq_ready <= 1'b0;
		rec(1'b0, 1'b0);
		frame(4, 0, 0, 1);
		rdchk(`OFS_MISS_CNT, 32'd4);
		acq_ready <= 1'b1;
		// reference with one pulse skipped, lock on the second, and a shifted zero
		shift = 32'h0024_199A;
		wr(`OFS_SHIFT, shift);
		wr(`OFS_SKIP, 32'd2);
		lock_at = 32'd8;
		rec(1'b0, 1'b1);
		frame(12, 4, 0, 1);
		rdchk(`OFS_REF_INDEX, 32'd8);
		rdchk(`OFS_STATUS, 32'h3);
		wr(`OFS_QUERY_IDX, 32'd5);
		rdchk(`OFS_QUERY_POS, shift - 32'd3 * 32'h3D70);
		wr(`OFS_QUERY_IDX, 32'd10);
		rdchk(`OFS_QUERY_POS, shift + 32'd2 * 32'h3D70);
		// qualifier picks the second reference of the 720 degree cycle
		wr(`OFS_SKIP, 32'd0);
		rec(1'b1, 1'b1);
		frame(12, 4, 8, 1);
		rdchk(`OFS_REF_INDEX, 32'd8);
		conclude();
	end

endmodule // testbench
